// [bench/can_node_model.sv]
// Model of the other CAN nodes: turns one requested bus event into a
// one-cycle event pulse. Assumes the bench raises go for one cycle.
`timescale 1ns/1ps
module can_node_model
  import can_status_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [3:0] num,
  output can_status_pkg::can_event_type ev
);
  import can_status_pkg::*;
  // Kinds: 0 tx, 1 rx, 2 overflow, 3 almost full, 4 wake-up, 5 invalid, 6 filter
  wire logic [6:0] v = go ? 7'h01 << kind : 7'h00;
  always_ff @(posedge clk)
  begin
    ev <= {v[5], v[4], v[3], v[2], v[1], v[0], num, v[6], num};
  end
endmodule

// [bench/can_status_irq_fifo_regs_tb.sv]
// Self-checking bench for the CAN status and interrupt registers.
// Assumes the package constants and the one-cycle strobe register port.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module can_status_irq_fifo_regs_tb;
  import can_status_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  reg_req_type reg_req = '0;
  logic [2:0] op_mode = 3'h0;
  can_event_type events;
  err_state_type err_state = '0;
  logic [3:0] tx_err_up = 4'h0;
  logic [3:0] rx_err_up = 4'h0;
  logic tx_err_down = 0;
  logic rx_err_down = 0;
  logic fifo_write_done = 0;
  logic fifo_read_done = 0;
  logic go = 0;
  logic [2:0] kind = 3'h0;
  logic [3:0] num = 4'h0;
  logic [15:0] rdata;
  logic irq, compare_count_invalid;
  logic [17:0] id_compare_mask;
  logic [5:0] buffer_area_count, fifo_write_pointer, fifo_read_pointer;
  logic [4:0] fifo_start;
  int n_fail = 0;
  int cmp_count = 0;
  integer seed = 32'hfa6691ae;
  logic [4:0] cnt [5] = '{5'h00, 5'h01, 5'h11, 5'h12, 5'h1f};
  logic [5:0] sizes [8] = '{6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h20, 6'h00};
  int fbit [6] = '{0, 1, 2, 3, 6, 7};
  logic [6:0] code [6] = '{7'h00, 7'h00, 7'h43, 7'h44, 7'h42, 7'h40};

  // Expected compare mask: one bit per identifier bit reached, none when invalid
  function automatic logic [17:0] exp_mask(input logic [4:0] c);
    exp_mask = c > 5'h11 ? 18'h00000 : (18'h00001 << c) - 18'h00001;
  endfunction

  // Expected next FIFO pointer: wraps to the start at the end of the area
  function automatic logic [5:0] exp_next(input logic [5:0] ptr, input logic [5:0] size,
    input logic [5:0] first);
    exp_next = ptr + 6'h01 >= size ? first : ptr + 6'h01;
  endfunction

  always #25 clk = ~clk;

  can_status_irq_fifo_regs dut (.clk, .rstn, .reg_req, .rdata, .op_mode, .events, .err_state,
    .tx_err_up, .tx_err_down, .rx_err_up, .rx_err_down, .fifo_write_done, .fifo_read_done,
    .irq, .id_compare_mask, .compare_count_invalid, .buffer_area_count, .fifo_start,
    .fifo_write_pointer, .fifo_read_pointer);
  can_node_model node (.clk, .go, .kind, .num, .ev(events));

  // ====
  // Bus and stimulus tasks
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m,
    input string nm);
    @(posedge clk);
    reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    `CHK(nm, e & m, rdata & m)
  endtask

  task automatic fire(input logic [2:0] k, input logic [3:0] n);
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    num <= n;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test;
  end

  // ====
  // Main sequence
  initial
  begin
    logic [15:0] q, r;
    logic [5:0] p;
    logic [4:0] n;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 7; a++)
      rchk(a[2:0], a == 1 ? 16'h0040 : 16'h0000, 16'hffff, "reset word");
    wr(OFF_INTERRUPT_ENABLES, 16'hffff);
    rchk(OFF_INTERRUPT_ENABLES, 16'h00ef, 16'hffff, "enables");
    wr(OFF_ERROR_COUNTS, 16'hffff);
    rchk(OFF_ERROR_COUNTS, 16'h0000, 16'hffff, "counts read-only");
    for (int i = 0; i < 6; i++)
    begin
      r = 16'($random(seed));
      n = i < 5 ? cnt[i] : r[4:0];
      wr(OFF_COMPARE_SETUP, {11'h000, n});
      rchk(OFF_DATA_BYTE_FILTER_CTRL, {11'h000, n}, 16'hffff, "compare count");
      `CHK("invalid", n > 5'h11, compare_count_invalid)
      `CHK("mask", exp_mask(n), id_compare_mask)
    end
    for (int c = 0; c < 8; c++)
    begin
      r = 16'($random(seed));
      q = {c[2:0], 8'h00, r[4:0]};
      wr(OFF_FIFO_AREA_CONTROL, q | 16'h1fe0);
      rchk(OFF_FIFO_AREA_CONTROL, q, 16'hffff, "fifo control");
      `CHK("area", sizes[c], buffer_area_count)
      `CHK("write ptr", {1'b0, q[4:0]}, fifo_write_pointer)
    end
    wr(OFF_FIFO_AREA_CONTROL, 16'h0001);
    p = 6'h01;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      fifo_write_done <= 1'b1;
      fifo_read_done <= 1'b1;
      @(posedge clk);
      fifo_write_done <= 1'b0;
      fifo_read_done <= 1'b0;
      p = exp_next(p, sizes[0], 6'h01);
      rchk(OFF_FIFO_POINTER_STATUS, {2'b00, p, 2'b00, p}, 16'hffff, "pointers");
    end
    wr(OFF_FIFO_POINTER_STATUS, 16'hffff);
    rchk(OFF_FIFO_POINTER_STATUS, {2'b00, p, 2'b00, p}, 16'hffff, "status read-only");
    for (int k = 0; k < 6; k++)
    begin
      r = 16'($random(seed));
      fire(k[2:0], r[3:0]);
      q = 16'h0001 << fbit[k];
      wr(OFF_INTERRUPT_FLAGS, 16'hffff);
      rchk(OFF_INTERRUPT_FLAGS, q, 16'hffff, "flag");
      `CHK("irq set", 1'b1, irq)
      rchk(OFF_INTERRUPT_CODE_VECTOR, {9'h000, k < 2 ? {3'h0, r[3:0]} : code[k]}, 16'h007f,
        "code");
      wr(OFF_INTERRUPT_ENABLES, 16'h0000);
      `CHK("irq masked", 1'b0, irq)
      wr(OFF_INTERRUPT_ENABLES, 16'h00ff);
      wr(OFF_INTERRUPT_FLAGS, ~q);
      `CHK("irq clear", 1'b0, irq)
    end
    fire(3'h6, 4'hf);
    rchk(OFF_INTERRUPT_CODE_VECTOR, 16'h0f40, 16'hffff, "filter hit");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      err_state <= err_state_type'(5'h01 << i);
      rchk(OFF_INTERRUPT_FLAGS, (16'h0200 << i) | (i < 2 ? 16'h0120 : 16'h0020), 16'hffff,
        "error state");
      @(posedge clk);
      err_state <= '0;
      wr(OFF_INTERRUPT_FLAGS, 16'hff00);
    end
    r = 16'($random(seed));
    @(posedge clk);
    tx_err_up <= 4'h8;
    rx_err_up <= r[3:0];
    @(posedge clk);
    tx_err_up <= 4'h0;
    rx_err_up <= 4'h0;
    rchk(OFF_ERROR_COUNTS, {8'h08, 4'h0, r[3:0]}, 16'hffff, "counts");
    @(posedge clk);
    op_mode <= MODE_DISABLE;
    @(posedge clk);
    tx_err_up <= 4'h4;
    @(posedge clk);
    tx_err_up <= 4'h0;
    fire(3'h4, 4'h0);
    fire(3'h1, 4'h3);
    rchk(OFF_ERROR_COUNTS, {8'h08, 4'h0, r[3:0]}, 16'hffff, "counts held");
    rchk(OFF_INTERRUPT_FLAGS, 16'h0040, 16'hffff, "wake-up only");
    @(posedge clk);
    op_mode <= MODE_CONFIG;
    repeat (2) @(posedge clk);
    rchk(OFF_ERROR_COUNTS, 16'h0000, 16'hffff, "counts cleared");
    rchk(OFF_INTERRUPT_FLAGS, 16'h0040, 16'hffff, "flags kept");
    // Overflow event and a clear of every flag land on the same edge
    @(posedge clk);
    go <= 1'b1;
    kind <= 3'h2;
    @(posedge clk);
    go <= 1'b0;
    reg_req <= '{OFF_INTERRUPT_FLAGS, 16'h0000, 1'b1, 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
    rchk(OFF_INTERRUPT_FLAGS, 16'h0004, 16'hffff, "set beats clear");
    stop_test;
  end
endmodule

// [bench/can_status_props.sv]
// Checker for the CAN status, interrupt and FIFO pointer registers.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module can_status_props
  import can_status_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire can_status_pkg::reg_req_type reg_req,
  input wire logic [15:0] rdata,
  input wire logic fifo_write_done,
  input wire logic fifo_read_done,
  input wire logic irq,
  input wire logic [17:0] id_compare_mask,
  input wire logic compare_count_invalid,
  input wire logic [5:0] buffer_area_count,
  input wire logic [4:0] fifo_start,
  input wire logic [5:0] fifo_write_pointer,
  input wire logic [5:0] fifo_read_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic w_area = reg_req.wr && reg_req.addr == OFF_FIFO_AREA_CONTROL;
  wire logic w_cmp = reg_req.wr && reg_req.addr == OFF_COMPARE_SETUP;
  wire logic r_flag = reg_req.rd && reg_req.addr == OFF_INTERRUPT_FLAGS;
  wire logic r_en = reg_req.rd && reg_req.addr == OFF_INTERRUPT_ENABLES;
  wire logic r_vec = reg_req.rd && reg_req.addr == OFF_INTERRUPT_CODE_VECTOR;

  function automatic logic [5:0] size_of(input logic [2:0] c);
    size_of = (c == 3'h7) ? 6'h00 : (c[0] ? 6'h06 : 6'h04) << c[2:1];
  endfunction

  // ====
  // Properties
  a_area_size: assert property ($past(w_area) |->
    buffer_area_count == size_of($past(reg_req.wdata[15:13]))) else $error("area size");
  a_start_load: assert property ($past(w_area) |-> fifo_start == $past(reg_req.wdata[4:0])
    && fifo_write_pointer == {1'b0, fifo_start}) else $error("fifo start load");
  a_ptr_range: assert property (fifo_write_pointer <= POINTER_LAST
    && fifo_read_pointer <= POINTER_LAST) else $error("pointer range");
  a_ptr_hold: assert property ($past(reg_req.wr && reg_req.addr == OFF_FIFO_POINTER_STATUS
    && !fifo_write_done && !fifo_read_done) |-> $stable(fifo_read_pointer)) else $error("ptr");
  a_count_invalid: assert property ($past(w_cmp) |->
    compare_count_invalid == ($past(reg_req.wdata[4:0]) > 5'h11)) else $error("invalid");
  a_mask_shape: assert property ($past(w_cmp, 2) && !$past(w_cmp) |-> id_compare_mask ==
    ($past(reg_req.wdata[4:0], 2) > 5'h11 ? 18'h0 : (18'h1 << $past(reg_req.wdata[4:0], 2))
    - 18'h1)) else $error("compare mask");
  a_irq_masked: assert property ($past(reg_req.wr && reg_req.addr == OFF_INTERRUPT_ENABLES
    && reg_req.wdata[7:0] == 8'h00) |-> !irq) else $error("irq while masked");
  a_flag_layout: assert property ($past(r_flag) |-> rdata[15:14] == 2'b00 && !rdata[4]
    ) else $error("flag layout");
  a_warn_any: assert property ($past(r_flag) |-> rdata[8] == (rdata[10] | rdata[9]))
    else $error("combined warning");
  a_enable_layout: assert property ($past(r_en) |-> rdata[15:8] == 8'h00 && !rdata[4])
    else $error("enable layout");
  a_idle_code: assert property ($past(r_vec && !irq) |-> rdata[6:0] == CODE_NO_INT
    && rdata[15:13] == 3'h0) else $error("idle code");
  c_irq: cover property (irq);
  c_invalid: cover property (compare_count_invalid);
  c_wrap: cover property (fifo_write_done ##1 fifo_write_pointer == {1'b0, fifo_start});
endmodule

bind can_status_irq_fifo_regs can_status_props chk (.clk, .rstn, .reg_req, .rdata,
  .fifo_write_done, .fifo_read_done, .irq, .id_compare_mask, .compare_count_invalid,
  .buffer_area_count, .fifo_start, .fifo_write_pointer, .fifo_read_pointer);

// [verilog/can_status_irq_fifo_regs.sv]
// Status, interrupt, receive FIFO pointer and error count registers.
// Assumes a protocol engine that pulses events and drives error states,
// and a register master that follows the one-cycle strobe port.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// Behaviour
// - 5-bit compare count; zero off, high invalid
// - Nonzero count compares data bits with identifier
// - Read-only matched filter number, zero to fifteen
// - Fixed interrupt codes for status interrupts
// - Buffer interrupts report buffer number as code
// - 3-bit code sets buffer area size
// - Writable FIFO start buffer field
// - Read-only FIFO next write pointer
// - Read-only FIFO next read pointer, low bits
// - Read-only error states plus combined warning
// - Error flag set by any error state
// - Interrupt flags cleared by software, never set
// - FIFO, overflow, receive, transmit flags at 3..0
// - Disabled mode keeps wake-up, flags, counts
// - Entering initialization clears counts, keeps flags
module can_status_irq_fifo_regs
  import can_status_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire can_status_pkg::reg_req_type reg_req,
  output logic [15:0] rdata,
  input wire logic [2:0] op_mode,
  input wire can_status_pkg::can_event_type events,
  input wire can_status_pkg::err_state_type err_state,
  input wire logic [3:0] tx_err_up,
  input wire logic tx_err_down,
  input wire logic [3:0] rx_err_up,
  input wire logic rx_err_down,
  input wire logic fifo_write_done,
  input wire logic fifo_read_done,
  output logic irq,
  output logic [17:0] id_compare_mask,
  output logic compare_count_invalid,
  output logic [5:0] buffer_area_count,
  output logic [4:0] fifo_start,
  output logic [5:0] fifo_write_pointer,
  output logic [5:0] fifo_read_pointer
);
  import can_status_pkg::*;

  // ==========================================================
  // State
  logic [15:0] rdata_q;
  logic [4:0] compare_count_q;
  logic [ID_COMPARE_BITS-1:0] mask_q;
  logic [4:0] matched_filter_q;
  logic [3:0] buffer_number_q;
  logic [2:0] area_size_q;
  logic [4:0] start_q;
  logic [5:0] write_ptr_q;
  logic [5:0] write_ptr_d;
  logic [5:0] read_ptr_q;
  logic [5:0] read_ptr_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] enables_q;
  logic [5:0] err_state_q;
  logic [7:0] tx_count_q;
  logic [7:0] tx_count_d;
  logic [7:0] rx_count_q;
  logic [7:0] rx_count_d;
  logic [2:0] mode_q;

  // ==========================================================
  // Register decode
  wire wr_fctrl = reg_req.wr && (reg_req.addr == OFF_FIFO_AREA_CONTROL);
  wire wr_flags = reg_req.wr && (reg_req.addr == OFF_INTERRUPT_FLAGS);
  wire wr_enables = reg_req.wr && (reg_req.addr == OFF_INTERRUPT_ENABLES);
  wire wr_setup = reg_req.wr && (reg_req.addr == OFF_COMPARE_SETUP);

  // ==========================================================
  // Data byte compare control
  wire count_invalid = compare_count_q > COMPARE_COUNT_MAX;
  wire [4:0] count_used = count_invalid ? 5'h00 : compare_count_q;

  // One mask bit per identifier bit reached by the count
  genvar gi;
  generate
    for (gi = 0; gi < ID_COMPARE_BITS; gi = gi + 1)
    begin : g_mask
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          mask_q[gi] <= 1'b0;
        else
          mask_q[gi] <= count_used > 5'(gi);
      end
    end
  endgenerate

  // ==========================================================
  // Error state and interrupt flags
  wire any_warning = err_state.tx_warning || err_state.rx_warning;
  wire [5:0] err_state_now = {err_state.tx_bus_off,
                              err_state.tx_error_passive,
                              err_state.rx_error_passive,
                              err_state.tx_warning,
                              err_state.rx_warning,
                              any_warning};
  wire err_rise = |(err_state_now & ~err_state_q);
  wire disabled = op_mode == MODE_DISABLE;
  wire active = !disabled;

  wire [7:0] flag_set;
  assign flag_set[FLAG_INVALID] = active && events.invalid_msg;
  assign flag_set[FLAG_WAKEUP] = events.wakeup;
  assign flag_set[FLAG_ERROR] = active && err_rise;
  assign flag_set[4] = 1'b0;
  assign flag_set[FLAG_FIFO] = active && events.fifo_almost_full;
  assign flag_set[FLAG_OVERFLOW] = active && events.rx_overflow;
  assign flag_set[FLAG_RX] = active && events.rx_buffer;
  assign flag_set[FLAG_TX] = active && events.tx_buffer;

  // Writing zero clears a flag, writing one leaves it; a set wins
  wire [7:0] flag_clear = wr_flags ? ~reg_req.wdata[7:0] : 8'h00;
  assign flags_d = ((flags_q & ~flag_clear) | flag_set) & FLAG_IMPL_MASK;

  wire [7:0] pending = flags_q & enables_q;
  assign irq = |pending;

  // ==========================================================
  // Interrupt code, error first, then wake-up, overflow, FIFO, buffers
  wire buffer_pending = pending[FLAG_RX] || pending[FLAG_TX];
  wire [6:0] interrupt_code =
    pending[FLAG_ERROR] ? CODE_ERROR :
    pending[FLAG_WAKEUP] ? CODE_WAKEUP :
    pending[FLAG_OVERFLOW] ? CODE_OVERFLOW :
    pending[FLAG_FIFO] ? CODE_FIFO_FULL :
    buffer_pending ? {3'b000, buffer_number_q} :
    CODE_NO_INT;

  // ==========================================================
  // FIFO pointers wrap from the last buffer of the area to the start
  wire [5:0] area_count = area_buffers(area_size_q);
  wire [5:0] start_ptr = {1'b0, start_q};

  function automatic logic [5:0] advance(input logic [5:0] ptr,
                                         input logic [5:0] area,
                                         input logic [5:0] first);
    logic [5:0] nxt;
    nxt = ptr + 6'h01;
    if (nxt >= area || ptr >= POINTER_LAST)
      advance = first;
    else
      advance = nxt;
  endfunction

  wire [5:0] write_next = advance(write_ptr_q, area_count, start_ptr);
  wire [5:0] read_next = advance(read_ptr_q, area_count, start_ptr);

  assign write_ptr_d = wr_fctrl ? {1'b0, reg_req.wdata[4:0]} :
                       (fifo_write_done && active) ? write_next :
                       write_ptr_q;
  assign read_ptr_d = wr_fctrl ? {1'b0, reg_req.wdata[4:0]} :
                      fifo_read_done ? read_next :
                      read_ptr_q;

  // ==========================================================
  // Error counters saturate; held when disabled, cleared on init entry
  wire entering_init = (op_mode == MODE_CONFIG) && (mode_q != MODE_CONFIG);
  wire [8:0] tx_sum = {1'b0, tx_count_q} + {5'h00, tx_err_up};
  wire [8:0] rx_sum = {1'b0, rx_count_q} + {5'h00, rx_err_up};
  wire [7:0] tx_up = tx_sum[8] ? COUNT_SATURATED : tx_sum[7:0];
  wire [7:0] rx_up = rx_sum[8] ? COUNT_SATURATED : rx_sum[7:0];
  wire tx_dec = tx_err_down && (tx_count_q != RST_COUNT);
  wire rx_dec = rx_err_down && (rx_count_q != RST_COUNT);

  assign tx_count_d =
    entering_init ? RST_COUNT :
    disabled ? tx_count_q :
    (tx_err_up != 4'h0) ? tx_up :
    tx_dec ? tx_count_q - 8'h01 :
    tx_count_q;
  assign rx_count_d =
    entering_init ? RST_COUNT :
    disabled ? rx_count_q :
    (rx_err_up != 4'h0) ? rx_up :
    rx_dec ? rx_count_q - 8'h01 :
    rx_count_q;

  // ==========================================================
  // Read mux; unmapped bits read as zero
  logic [15:0] rd_word;
  always_comb
  begin
    rd_word = RST_WORD;
    case (reg_req.addr)
      OFF_DATA_BYTE_FILTER_CTRL:
        rd_word[4:0] = compare_count_q;
      OFF_INTERRUPT_CODE_VECTOR:
      begin
        rd_word[FILTER_NUM_LSB +: 5] = matched_filter_q;
        rd_word[6:0] = interrupt_code;
      end
      OFF_FIFO_AREA_CONTROL:
      begin
        rd_word[AREA_SIZE_LSB +: 3] = area_size_q;
        rd_word[4:0] = start_q;
      end
      OFF_FIFO_POINTER_STATUS:
      begin
        rd_word[WRITE_PTR_LSB +: 6] = write_ptr_q;
        rd_word[5:0] = read_ptr_q;
      end
      OFF_INTERRUPT_FLAGS:
      begin
        rd_word[ERR_STATE_LSB +: 6] = err_state_q;
        rd_word[7:0] = flags_q;
      end
      OFF_INTERRUPT_ENABLES:
        rd_word[7:0] = enables_q;
      OFF_ERROR_COUNTS:
      begin
        rd_word[TX_COUNT_LSB +: 8] = tx_count_q;
        rd_word[7:0] = rx_count_q;
      end
      OFF_COMPARE_SETUP:
        rd_word[4:0] = compare_count_q;
      default:
        rd_word = RST_WORD;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= RST_WORD;
    else
      rdata_q <= reg_req.rd ? rd_word : RST_WORD;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      compare_count_q <= RST_FIELD5;
    else if (wr_setup)
      compare_count_q <= reg_req.wdata[4:0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      area_size_q <= RST_AREA;
      start_q <= RST_FIELD5;
    end
    else if (wr_fctrl)
    begin
      area_size_q <= reg_req.wdata[AREA_SIZE_LSB +: 3];
      start_q <= reg_req.wdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      write_ptr_q <= RST_POINTER;
      read_ptr_q <= RST_POINTER;
    end
    else
    begin
      write_ptr_q <= write_ptr_d;
      read_ptr_q <= read_ptr_d;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      matched_filter_q <= RST_FIELD5;
    else if (events.filter_hit && active)
      matched_filter_q <= {1'b0, events.filter_number};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      buffer_number_q <= RST_BUF;
    else if ((events.rx_buffer || events.tx_buffer) && active)
      buffer_number_q <= events.buffer_number;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_q <= RST_FLAGS;
      err_state_q <= RST_ERR_STATE;
    end
    else
    begin
      flags_q <= flags_d;
      err_state_q <= err_state_now;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      enables_q <= RST_FLAGS;
    else if (wr_enables)
      enables_q <= reg_req.wdata[7:0] & FLAG_IMPL_MASK;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_count_q <= RST_COUNT;
      rx_count_q <= RST_COUNT;
      mode_q <= RST_MODE;
    end
    else
    begin
      tx_count_q <= tx_count_d;
      rx_count_q <= rx_count_d;
      mode_q <= op_mode;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = rdata_q;
  assign id_compare_mask = mask_q;
  assign compare_count_invalid = count_invalid;
  assign buffer_area_count = area_count;
  assign fifo_start = start_q;
  assign fifo_write_pointer = write_ptr_q;
  assign fifo_read_pointer = read_ptr_q;

endmodule

// [verilog/can_status_pkg.sv]
// Constants, field layout and carrier types for the CAN status block.
// Assumes a 16-bit register port with an 8-word map and one clock.
package can_status_pkg;

  // ==========================================================
  // Register map (word index on reg_req.addr)
  localparam logic [2:0] OFF_DATA_BYTE_FILTER_CTRL = 3'h0;
  localparam logic [2:0] OFF_INTERRUPT_CODE_VECTOR = 3'h1;
  localparam logic [2:0] OFF_FIFO_AREA_CONTROL = 3'h2;
  localparam logic [2:0] OFF_FIFO_POINTER_STATUS = 3'h3;
  localparam logic [2:0] OFF_INTERRUPT_FLAGS = 3'h4;
  localparam logic [2:0] OFF_INTERRUPT_ENABLES = 3'h5;
  localparam logic [2:0] OFF_ERROR_COUNTS = 3'h6;
  localparam logic [2:0] OFF_COMPARE_SETUP = 3'h7;

  // ==========================================================
  // Field positions
  localparam int FILTER_NUM_LSB = 8;
  localparam int AREA_SIZE_LSB = 13;
  localparam int WRITE_PTR_LSB = 8;
  localparam int ERR_STATE_LSB = 8;
  localparam int TX_COUNT_LSB = 8;
  localparam int FLAG_INVALID = 7;
  localparam int FLAG_WAKEUP = 6;
  localparam int FLAG_ERROR = 5;
  localparam int FLAG_FIFO = 3;
  localparam int FLAG_OVERFLOW = 2;
  localparam int FLAG_RX = 1;
  localparam int FLAG_TX = 0;
  localparam logic [7:0] FLAG_IMPL_MASK = 8'hef;

  // ==========================================================
  // Codes and limits
  localparam logic [4:0] COMPARE_COUNT_MAX = 5'h11;
  localparam int ID_COMPARE_BITS = 18;
  localparam logic [6:0] CODE_NO_INT = 7'h40;
  localparam logic [6:0] CODE_ERROR = 7'h41;
  localparam logic [6:0] CODE_WAKEUP = 7'h42;
  localparam logic [6:0] CODE_OVERFLOW = 7'h43;
  localparam logic [6:0] CODE_FIFO_FULL = 7'h44;
  localparam logic [2:0] MODE_DISABLE = 3'h1;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [5:0] POINTER_LAST = 6'h1f;
  localparam logic [7:0] COUNT_SATURATED = 8'hff;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [5:0] RST_POINTER = 6'h00;
  localparam logic [4:0] RST_FIELD5 = 5'h00;
  localparam logic [2:0] RST_AREA = 3'h0;
  localparam logic [2:0] RST_MODE = 3'h4;
  localparam logic [3:0] RST_BUF = 4'h0;
  localparam logic [5:0] RST_ERR_STATE = 6'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic invalid_msg;
    logic wakeup;
    logic fifo_almost_full;
    logic rx_overflow;
    logic rx_buffer;
    logic tx_buffer;
    logic [3:0] buffer_number;
    logic filter_hit;
    logic [3:0] filter_number;
  } can_event_type;

  typedef struct packed {
    logic tx_bus_off;
    logic tx_error_passive;
    logic rx_error_passive;
    logic tx_warning;
    logic rx_warning;
  } err_state_type;

  // Buffers held in DMA RAM for each area size code; reserved code gives 0
  function automatic logic [5:0] area_buffers(input logic [2:0] code);
    case (code)
      3'h0: area_buffers = 6'h04;
      3'h1: area_buffers = 6'h06;
      3'h2: area_buffers = 6'h08;
      3'h3: area_buffers = 6'h0c;
      3'h4: area_buffers = 6'h10;
      3'h5: area_buffers = 6'h18;
      3'h6: area_buffers = 6'h20;
      default: area_buffers = 6'h00;
    endcase
  endfunction

endpackage
